// >>> video_decoder_ctrl_regs.sv
// converter, field timing, soft reset, white crush and timing ram load registers
`timescale 1ns/1ps
module video_decoder_ctrl_regs
  import video_decoder_ctrl_pkg::*;
#(
  parameter int RAM_DEPTH = TIMING_RAM_DEPTH,
  parameter int RAM_AW    = $clog2(TIMING_RAM_DEPTH)
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_line_start,
  input  wire logic              i_field_end,
  input  wire logic              i_field_odd,
  output logic [7:0]             o_reg_rdata,
  output logic                   o_reg_rvalid,
  output logic                   o_converter_ref_drive,
  output logic                   o_decoder_clk_enable,
  output logic                   o_luma_sleep,
  output logic                   o_chroma_sleep,
  output logic                   o_adaptive_gain,
  output logic                   o_horizontal_reset_pulse_n,
  output logic [2:0]             o_vertical_filter_taps,
  output logic                   o_vsync_presence_enable,
  output logic                   o_crush_rate_select,
  output logic [CRUSH_ACC_W-1:0] o_crush_down_total,
  output logic                   o_timing_gen_run_mode,
  output logic [RAM_AW-1:0]      o_timing_ram_addr
);

  logic [7:0]        adc_reg;
  logic [7:0]        even_timing_reg;
  logic [7:0]        odd_timing_reg;
  logic [7:0]        crush_reg;
  logic [7:0]        tg_ctrl_reg;
  logic [7:0]        ram_mem [RAM_DEPTH];
  logic [7:0]        tg_ctrl_next;
  logic [7:0]        active_timing;
  logic              soft_clear;
  logic              clk_run;
  logic              wr_adc;
  logic              wr_even;
  logic              wr_odd;
  logic              wr_crush;
  logic              wr_soft;
  logic              wr_load;
  logic              wr_tg;
  logic              addr_step;
  logic              addr_clear;
  logic              horizontal_reset_pulse_n;
  logic [CRUSH_ACC_W-1:0] crush_total;
  soft_reset_state_t sr_state_reg;
  soft_reset_state_t sr_state_next;

  // register address match on a write strobe
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [11:0]       offset);
    hit = (addr == offset);
  endfunction

  // write decode
  assign wr_adc   = i_reg_wr && hit(i_reg_addr, OFF_ADC_INTERFACE_CTRL);
  assign wr_even  = i_reg_wr && hit(i_reg_addr, OFF_EVEN_FIELD_TIMING);
  assign wr_odd   = i_reg_wr && hit(i_reg_addr, OFF_ODD_FIELD_TIMING);
  assign wr_crush = i_reg_wr && hit(i_reg_addr, OFF_WHITE_CRUSH_DOWN);
  assign wr_soft  = i_reg_wr && hit(i_reg_addr, OFF_SOFT_RESET_COMMAND);
  assign wr_load  = i_reg_wr && hit(i_reg_addr, OFF_TIMING_RAM_LOAD);
  assign wr_tg    = i_reg_wr && hit(i_reg_addr, OFF_TIMING_GEN_CTRL);

  // step and clear act on a rising edge of the written control bits
  assign tg_ctrl_next = i_reg_wdata & TG_WRITE_MASK;
  assign addr_step  = wr_tg && tg_ctrl_next[TG_ADDR_STEP_BIT]
                      && !tg_ctrl_reg[TG_ADDR_STEP_BIT];
  assign addr_clear = wr_tg && tg_ctrl_next[TG_ADDR_CLEAR_BIT]
                      && !tg_ctrl_reg[TG_ADDR_CLEAR_BIT];

  // soft reset: any data value arms, clear is applied two edges later
  always_comb begin
    sr_state_next = sr_state_reg;
    unique case (sr_state_reg)
      SR_IDLE:  if (wr_soft) sr_state_next = SR_ARM;
      SR_ARM:   sr_state_next = SR_APPLY;
      SR_APPLY: sr_state_next = wr_soft ? SR_ARM : SR_IDLE;
      default:  sr_state_next = SR_IDLE;
    endcase
  end

  // soft reset state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sr_state_reg <= SR_IDLE;
    end else begin
      sr_state_reg <= sr_state_next;
    end
  end

  assign soft_clear = (sr_state_reg == SR_APPLY);
  assign clk_run    = !adc_reg[ADC_CLK_SLEEP_BIT];

  // converter interface register, reserved bits held at their fixed values
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      adc_reg <= RST_ADC_INTERFACE_CTRL;
    end else if (soft_clear) begin
      adc_reg <= RST_ADC_INTERFACE_CTRL;
    end else if (wr_adc) begin
      adc_reg <= {2'b10, 1'b0, i_reg_wdata[4:0]};
    end
  end

  // field timing registers, reserved bits read zero
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      even_timing_reg <= RST_FIELD_TIMING;
      odd_timing_reg  <= RST_FIELD_TIMING;
    end else if (soft_clear) begin
      even_timing_reg <= RST_FIELD_TIMING;
      odd_timing_reg  <= RST_FIELD_TIMING;
    end else begin
      if (wr_even) begin
        even_timing_reg <= i_reg_wdata & VTC_WRITE_MASK;
      end
      if (wr_odd) begin
        odd_timing_reg <= i_reg_wdata & VTC_WRITE_MASK;
      end
    end
  end

  // white crush register, writable except in the cycle a soft clear is applied
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      crush_reg <= RST_WHITE_CRUSH_DOWN;
    end else if (soft_clear) begin
      crush_reg <= RST_WHITE_CRUSH_DOWN;
    end else if (wr_crush) begin
      crush_reg <= i_reg_wdata;
    end
  end

  // timing generator control bits
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tg_ctrl_reg <= RST_TIMING_GEN_CTRL;
    end else if (soft_clear) begin
      tg_ctrl_reg <= RST_TIMING_GEN_CTRL;
    end else if (wr_tg) begin
      tg_ctrl_reg <= tg_ctrl_next;
    end
  end

  // timing ram byte location: clear, auto advance on load, manual step
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_timing_ram_addr <= '0;
    end else if (soft_clear || addr_clear) begin
      o_timing_ram_addr <= '0;
    end else if (wr_load && !tg_ctrl_reg[TG_RUN_MODE_BIT]) begin
      o_timing_ram_addr <= o_timing_ram_addr + 1'b1;
    end else if (addr_step) begin
      o_timing_ram_addr <= o_timing_ram_addr + 1'b1;
    end
  end

  // timing ram store at the location before the advance, only in load mode
  always_ff @(posedge i_clock) begin
    if (wr_load && !tg_ctrl_reg[TG_RUN_MODE_BIT] && !soft_clear && !addr_clear) begin
      ram_mem[o_timing_ram_addr] <= i_reg_wdata;
    end
  end

  // read data, one cycle after the read strobe; reads have no side effect
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          OFF_ADC_INTERFACE_CTRL: o_reg_rdata <= adc_reg;
          OFF_EVEN_FIELD_TIMING:  o_reg_rdata <= even_timing_reg;
          OFF_ODD_FIELD_TIMING:   o_reg_rdata <= odd_timing_reg;
          OFF_WHITE_CRUSH_DOWN:   o_reg_rdata <= crush_reg;
          OFF_TIMING_RAM_LOAD:    o_reg_rdata <= ram_mem[o_timing_ram_addr];
          OFF_TIMING_GEN_CTRL:    o_reg_rdata <= tg_ctrl_reg;
          OFF_SOFT_RESET_COMMAND: o_reg_rdata <= 8'h00;
          default:                o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // field selects its own timing register
  assign active_timing = i_field_odd ? odd_timing_reg : even_timing_reg;

  // registered converter controls, one cycle behind the register
  // reset levels match the converter register default, so no glitch at release
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_converter_ref_drive   <= 1'b1;
      o_decoder_clk_enable    <= 1'b1;
      o_luma_sleep            <= 1'b0;
      o_chroma_sleep          <= 1'b1;
      o_adaptive_gain         <= 1'b0;
    end else begin
      o_converter_ref_drive   <= !adc_reg[ADC_GAIN_DISABLE_BIT];
      o_decoder_clk_enable    <= clk_run;
      o_luma_sleep            <= adc_reg[ADC_LUMA_SLEEP_BIT];
      o_chroma_sleep          <= adc_reg[ADC_CHROMA_SLEEP_BIT];
      o_adaptive_gain         <= adc_reg[ADC_ADAPTIVE_BIT];
    end
  end

  // registered filter code of the current field
  // follows the field flag, so a field change shows one cycle later
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_vertical_filter_taps  <= 3'h0;
    end else begin
      o_vertical_filter_taps  <= active_timing[VTC_FILTER_MSB:0];
    end
  end

  // registered white crush controls
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_vsync_presence_enable <= 1'b0;
      o_crush_rate_select     <= 1'b1;
    end else begin
      o_vsync_presence_enable <= crush_reg[WC_VSYNC_SIGNAL_DETECTED_FLAG_BIT];
      o_crush_rate_select     <= crush_reg[WC_RATE_BIT];
    end
  end

  // registered timing generator mode
  // loads are gated by the register bit itself, not by this delayed copy
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_timing_gen_run_mode   <= 1'b0;
    end else begin
      o_timing_gen_run_mode   <= tg_ctrl_reg[TG_RUN_MODE_BIT];
    end
  end

  // horizontal reset pulse, held while the decoder clock is stopped
  horizontal_reset_pulse_pulse_gen u_horizontal_reset_pulse (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_enable     (clk_run),
    .i_line_start (i_line_start),
    .i_narrow     (active_timing[VTC_WIDTH_SEL_BIT]),
    .o_pulse_n    (horizontal_reset_pulse_n)
  );

  assign o_horizontal_reset_pulse_n = horizontal_reset_pulse_n;

  // white crush down-step accumulation
  crush_accum #(
    .ACC_W (CRUSH_ACC_W)
  ) u_crush (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_enable    (clk_run),
    .i_clear     (soft_clear),
    .i_field_end (i_field_end),
    .i_field_odd (i_field_odd),
    .i_per_frame (crush_reg[WC_RATE_BIT]),
    .i_down_step (crush_reg[WC_STEP_MSB:0]),
    .o_total     (crush_total)
  );

  assign o_crush_down_total = crush_total;

endmodule

// >>> video_decoder_ctrl_pkg.sv
// shared offsets, reset values and counts for the decoder control registers
package video_decoder_ctrl_pkg;

  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] OFF_ADC_INTERFACE_CTRL  = 12'h068;
  localparam logic [11:0] OFF_EVEN_FIELD_TIMING   = 12'h06c;
  localparam logic [11:0] OFF_WHITE_CRUSH_DOWN    = 12'h078;
  localparam logic [11:0] OFF_SOFT_RESET_COMMAND  = 12'h07c;
  localparam logic [11:0] OFF_TIMING_RAM_LOAD     = 12'h080;
  localparam logic [11:0] OFF_TIMING_GEN_CTRL     = 12'h084;
  localparam logic [11:0] OFF_ODD_FIELD_TIMING    = 12'h0ec;

  // reset values
  localparam logic [7:0] RST_ADC_INTERFACE_CTRL = 8'h82;
  localparam logic [7:0] RST_FIELD_TIMING       = 8'h00;
  localparam logic [7:0] RST_WHITE_CRUSH_DOWN   = 8'h7f;
  localparam logic [7:0] RST_TIMING_RAM_LOAD    = 8'h00;
  localparam logic [7:0] RST_TIMING_GEN_CTRL    = 8'h00;

  // converter interface register fields
  localparam int ADC_RSVD_HI_BIT      = 7;
  localparam int ADC_RSVD_LO_BIT      = 6;
  localparam int ADC_RSVD_ZERO_BIT    = 5;
  localparam int ADC_GAIN_DISABLE_BIT = 4;
  localparam int ADC_CLK_SLEEP_BIT    = 3;
  localparam int ADC_LUMA_SLEEP_BIT   = 2;
  localparam int ADC_CHROMA_SLEEP_BIT = 1;
  localparam int ADC_ADAPTIVE_BIT     = 0;

  // field timing register fields
  localparam int VTC_WIDTH_SEL_BIT = 7;
  localparam int VTC_FILTER_MSB    = 2;
  localparam logic [7:0] VTC_WRITE_MASK = 8'h87;

  // white crush register fields
  localparam int WC_VSYNC_SIGNAL_DETECTED_FLAG_BIT = 7;
  localparam int WC_RATE_BIT       = 6;
  localparam int WC_STEP_MSB       = 5;

  // timing generator control fields
  localparam int TG_ADDR_STEP_BIT  = 2;
  localparam int TG_ADDR_CLEAR_BIT = 1;
  localparam int TG_RUN_MODE_BIT   = 0;
  localparam logic [7:0] TG_WRITE_MASK = 8'h07;

  // horizontal reset pulse widths in pixel clocks
  localparam logic [6:0] HORIZONTAL_RESET_PULSE_WIDE_CYCLES   = 7'd64;
  localparam logic [6:0] HORIZONTAL_RESET_PULSE_NARROW_CYCLES = 7'd32;

  // timing ram and accumulator sizes
  localparam int TIMING_RAM_DEPTH = 256;
  localparam int CRUSH_ACC_W      = 12;

  // soft reset sequencer, one bit changes per step except apply back to idle
  typedef enum logic [1:0] {
    SR_IDLE  = 2'b00,
    SR_ARM   = 2'b01,
    SR_APPLY = 2'b11
  } soft_reset_state_t;

endpackage

// >>> horizontal_reset_pulse_pulse_gen.sv
// active-low horizontal reset pulse of selectable width
`timescale 1ns/1ps
module horizontal_reset_pulse_pulse_gen
  import video_decoder_ctrl_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_line_start,
  input  wire logic i_narrow,
  output logic      o_pulse_n
);

  logic [6:0] count_reg;

  // load the width on line start, count down while enabled
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= 7'h00;
      o_pulse_n <= 1'b1;
    end else if (i_enable) begin
      if (i_line_start) begin
        count_reg <= (i_narrow ? HORIZONTAL_RESET_PULSE_NARROW_CYCLES : HORIZONTAL_RESET_PULSE_WIDE_CYCLES) - 7'd1;
        o_pulse_n <= 1'b0;
      end else if (count_reg != 7'h00) begin
        count_reg <= count_reg - 7'd1;
      end else begin
        o_pulse_n <= 1'b1;
      end
    end
  end

endmodule

// >>> crush_accum.sv
// accumulates the negative white-crush down step per field or per frame
`timescale 1ns/1ps
module crush_accum
  import video_decoder_ctrl_pkg::*;
#(
  parameter int ACC_W = CRUSH_ACC_W
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_enable,
  input  wire logic             i_clear,
  input  wire logic             i_field_end,
  input  wire logic             i_field_odd,
  input  wire logic             i_per_frame,
  input  wire logic [5:0]       i_down_step,
  output logic [ACC_W-1:0]      o_total
);

  logic             step_now;
  logic [ACC_W:0]   sum;
  logic [ACC_W-1:0] step_ext;

  // step code read as negative: 3f is -1, 00 is -64
  assign step_ext = {{(ACC_W-6){1'b1}}, i_down_step};
  assign step_now = i_enable && i_field_end && (!i_per_frame || i_field_odd);
  assign sum      = {o_total[ACC_W-1], o_total} + {step_ext[ACC_W-1], step_ext};

  // add each step, clamp at the most negative value
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_total <= '0;
    end else if (i_clear) begin
      o_total <= '0;
    end else if (step_now) begin
      if (sum[ACC_W] != sum[ACC_W-1]) begin
        o_total <= {1'b1, {(ACC_W-1){1'b0}}};
      end else begin
        o_total <= sum[ACC_W-1:0];
      end
    end
  end

endmodule

// >>> video_decoder_ctrl_regs_monitor.sv
// concurrent checks on the decoder control register ports
`timescale 1ns/1ps
module video_decoder_ctrl_regs_monitor
  import video_decoder_ctrl_pkg::*;
#(
  parameter int RAM_AW = 8
) (
  input wire logic                   i_clock,
  input wire logic                   i_rst,
  input wire logic [ADDR_W-1:0]      i_reg_addr,
  input wire logic                   i_reg_wr,
  input wire logic                   i_reg_rd,
  input wire logic [7:0]             i_reg_wdata,
  input wire logic                   i_line_start,
  input wire logic                   o_reg_rvalid,
  input wire logic                   o_converter_ref_drive,
  input wire logic                   o_decoder_clk_enable,
  input wire logic                   o_chroma_sleep,
  input wire logic                   o_horizontal_reset_pulse_n,
  input wire logic [CRUSH_ACC_W-1:0] o_crush_down_total,
  input wire logic                   o_timing_gen_run_mode,
  input wire logic [RAM_AW-1:0]      o_timing_ram_addr
);
  logic       sr_wr;
  logic       quiet;
  logic       adc_wr;
  logic       load_wr;
  logic [1:0] sr_hist;
  logic [6:0] low_cnt;

  // writes that a pending soft clear could swallow are left out
  assign sr_wr = i_reg_wr && i_reg_addr == OFF_SOFT_RESET_COMMAND;
  assign quiet = !sr_wr && sr_hist == 2'b00;
  assign adc_wr = i_reg_wr && i_reg_addr == OFF_ADC_INTERFACE_CTRL && quiet;
  assign load_wr = i_reg_wr && i_reg_addr == OFF_TIMING_RAM_LOAD && quiet;

  // recent soft reset writes
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sr_hist <= 2'b00;
    end else begin
      sr_hist <= {sr_hist[0], sr_wr};
    end
  end

  // length of the current low stretch of the line reset pulse
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      low_cnt <= 7'h00;
    end else if (o_horizontal_reset_pulse_n || i_line_start) begin
      low_cnt <= 7'h00;
    end else if (o_decoder_clk_enable) begin
      low_cnt <= low_cnt + 7'h01;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered in the next cycle");
  a_no_spur_valid: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("read valid without a read");
  a_ref_follows: assert property (adc_wr |-> ##2
    (o_converter_ref_drive != $past(i_reg_wdata[ADC_GAIN_DISABLE_BIT], 2)))
    else $error("reference drive does not follow gain disable");
  a_clk_follows: assert property (adc_wr |-> ##2
    (o_decoder_clk_enable != $past(i_reg_wdata[ADC_CLK_SLEEP_BIT], 2)))
    else $error("clock enable does not follow clock sleep");
  a_chroma_follows: assert property (adc_wr |-> ##2
    (o_chroma_sleep == $past(i_reg_wdata[ADC_CHROMA_SLEEP_BIT], 2)))
    else $error("chroma sleep does not follow its bit");
  a_pulse_cause: assert property ($fell(o_horizontal_reset_pulse_n) |-> $past(i_line_start))
    else $error("line reset pulse began without a line start");
  a_pulse_bound: assert property (low_cnt <= 7'h40)
    else $error("line reset pulse longer than 64 cycles");
  a_ram_advance: assert property (load_wr && !o_timing_gen_run_mode |=>
    o_timing_ram_addr == $past(o_timing_ram_addr) + 1'b1)
    else $error("load byte write did not advance the address");
  a_ram_read_hold: assert property (i_reg_rd && i_reg_addr == OFF_TIMING_RAM_LOAD && quiet
    |=> $stable(o_timing_ram_addr))
    else $error("load byte read moved the address");
  a_run_blocks: assert property (load_wr && o_timing_gen_run_mode |=> $stable(o_timing_ram_addr))
    else $error("load byte write advanced in run mode");
  a_soft_clear: assert property (sr_wr |-> ##[2:3] (~|o_timing_ram_addr && ~|o_crush_down_total))
    else $error("soft reset did not clear address and total");
endmodule

// >>> reg_host_model.sv
// host software model: byte writes and reads on the register port
`timescale 1ns/1ps
module reg_host_model
  import video_decoder_ctrl_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic [7:0]        i_reg_rdata,
  input  wire logic              i_reg_rvalid,
  output logic [ADDR_W-1:0]      o_reg_addr,
  output logic                   o_reg_wr,
  output logic                   o_reg_rd,
  output logic [7:0]             o_reg_wdata
);
  // idle bus at time zero
  initial begin
    o_reg_addr = 12'h000;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // one-cycle write strobe; reserved bits of the converter and field timing registers are written as required
  task automatic put(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    logic [7:0] w;
    w = v;
    if (a == OFF_ADC_INTERFACE_CTRL) begin
      w = {2'b10, 1'b0, v[4:0]};
    end
    if (a == OFF_EVEN_FIELD_TIMING || a == OFF_ODD_FIELD_TIMING) begin
      w = v & VTC_WRITE_MASK;
    end
    // no scaler here, so any filter code assumes a width under 193 pixels
    @(negedge i_clock);
    o_reg_addr = a;
    o_reg_wdata = w;
    o_reg_wr = 1'b1;
    @(negedge i_clock);
    o_reg_wr = 1'b0;
    o_reg_wdata = ~w; // stale data never looks valid
  endtask

  // one-cycle read strobe; data is taken while valid stands
  task automatic get(input logic [ADDR_W-1:0] a, output logic [7:0] v, output logic ok);
    @(negedge i_clock);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_clock);
    v = i_reg_rdata;
    ok = i_reg_rvalid;
    o_reg_rd = 1'b0;
  endtask
endmodule

// >>> video_decoder_ctrl_regs_tb_top.sv
// self-checking bench for the decoder control registers
`timescale 1ns/1ps
module video_decoder_ctrl_regs_tb_top;
  import video_decoder_ctrl_pkg::*;
  logic                   i_clock, i_rst, i_line_start, i_field_end, i_field_odd;
  logic [ADDR_W-1:0]      i_reg_addr;
  logic                   i_reg_wr, i_reg_rd, o_reg_rvalid, o_converter_ref_drive;
  logic [7:0]             i_reg_wdata, o_reg_rdata, d, v, o_timing_ram_addr;
  logic                   o_decoder_clk_enable, o_luma_sleep, o_chroma_sleep;
  logic                   o_adaptive_gain, o_horizontal_reset_pulse_n, o_timing_gen_run_mode;
  logic                   o_vsync_presence_enable, o_crush_rate_select;
  logic [2:0]             o_vertical_filter_taps;
  logic [CRUSH_ACC_W-1:0] o_crush_down_total;
  logic [7:0]             bytes [4];
  logic [31:0]            rnd;
  int                     err_total, n_checks, k, n;

  video_decoder_ctrl_regs i_video_decoder_ctrl_regs (.i_clock, .i_rst, .i_reg_addr,
    .i_reg_wr, .i_reg_rd, .i_reg_wdata, .i_line_start, .i_field_end, .i_field_odd,
    .o_reg_rdata, .o_reg_rvalid, .o_converter_ref_drive, .o_decoder_clk_enable,
    .o_luma_sleep, .o_chroma_sleep, .o_adaptive_gain, .o_horizontal_reset_pulse_n,
    .o_vertical_filter_taps, .o_vsync_presence_enable, .o_crush_rate_select,
    .o_crush_down_total, .o_timing_gen_run_mode, .o_timing_ram_addr);
  reg_host_model i_reg_host_model (.i_clock, .i_reg_rdata(o_reg_rdata),
    .i_reg_rvalid(o_reg_rvalid), .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    i_reg_host_model.put(a, x);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic ok;
    i_reg_host_model.get(a, d, ok);
    chk({3'b000, ok, d}, {4'h1, e});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge i_clock);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // free-running clock
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    $display("watchdog expired");
    summarize();
  end
  // main sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    rnd = 32'h0fcba952;
    i_rst = 1'b1;
    i_line_start = 1'b0;
    i_field_end = 1'b0;
    i_field_odd = 1'b0;
    cyc(20);
    i_rst = 1'b0;
    chk({o_chroma_sleep, o_converter_ref_drive}, 12'h003);
    rchk(OFF_ADC_INTERFACE_CTRL, 8'h82);
    rchk(OFF_EVEN_FIELD_TIMING, 8'h00);
    rchk(OFF_ODD_FIELD_TIMING, 8'h00);
    rchk(OFF_WHITE_CRUSH_DOWN, 8'h7f);
    rchk(OFF_SOFT_RESET_COMMAND, 8'h00);
    rchk(12'h000, 8'h00);
    $display("test reset_values done");
    for (k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      v = (k == 0) ? 8'hff : rnd[7:0];
      wr(OFF_ADC_INTERFACE_CTRL, v);
      cyc(2);
      rchk(OFF_ADC_INTERFACE_CTRL, {3'b100, v[4:0]});
      chk({o_converter_ref_drive, o_decoder_clk_enable, o_luma_sleep, o_chroma_sleep,
        o_adaptive_gain}, {~v[4], ~v[3], v[2:0]});
    end
    wr(OFF_ADC_INTERFACE_CTRL, 8'h82);
    $display("test converter_ctrl done");
    for (k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      wr(OFF_EVEN_FIELD_TIMING, {rnd[7], 4'h0, k[2:0]});
      wr(OFF_ODD_FIELD_TIMING, {rnd[6], 4'h0, ~k[2:0]});
      i_field_odd = 1'b0;
      cyc(2);
      chk(o_vertical_filter_taps, k[2:0]);
      i_field_odd = 1'b1;
      cyc(2);
      chk(o_vertical_filter_taps, {~k[2:0]});
      rchk(OFF_EVEN_FIELD_TIMING, {rnd[7], 4'h0, k[2:0]});
    end
    $display("test field_timing done");
    wr(OFF_EVEN_FIELD_TIMING, 8'h80);
    wr(OFF_ODD_FIELD_TIMING, 8'h00);
    for (k = 0; k < 2; k++) begin
      i_field_odd = k[0];
      cyc(2);
      i_line_start = 1'b1;
      cyc(1);
      i_line_start = 1'b0;
      n = 0;
      repeat (100) begin
        n += int'(o_horizontal_reset_pulse_n === 1'b0);
        cyc(1);
      end
      chk(12'(n), k ? 12'h040 : 12'h020);
    end
    $display("test line_reset done");
    for (k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      wr(OFF_SOFT_RESET_COMMAND, rnd[7:0]);
      cyc(3);
      wr(OFF_WHITE_CRUSH_DOWN, {1'b1, k[0], rnd[13:8]});
      cyc(2);
      chk({o_vsync_presence_enable, o_crush_rate_select}, {1'b1, k[0]});
      for (n = 0; n < 4; n++) begin
        i_field_odd = n[0];
        i_field_end = 1'b1;
        cyc(1);
        i_field_end = 1'b0;
        cyc(1);
      end
      cyc(2);
      chk(o_crush_down_total, 12'((k ? 2 : 4) * ({6'h00, rnd[13:8]} - 12'h040)));
    end
    $display("test white_crush done");
    wr(OFF_TIMING_GEN_CTRL, 8'h02);
    wr(OFF_TIMING_GEN_CTRL, 8'h00);
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      bytes[k] = rnd[7:0];
      wr(OFF_TIMING_RAM_LOAD, bytes[k]);
    end
    chk(o_timing_ram_addr, 12'h004);
    wr(OFF_TIMING_GEN_CTRL, 8'h01);
    wr(OFF_TIMING_RAM_LOAD, 8'h5a);
    chk({o_timing_gen_run_mode, o_timing_ram_addr}, 12'h104);
    wr(OFF_TIMING_GEN_CTRL, 8'h02);
    wr(OFF_TIMING_GEN_CTRL, 8'h00);
    for (k = 0; k < 4; k++) begin
      rchk(OFF_TIMING_RAM_LOAD, bytes[k]);
      chk(o_timing_ram_addr, 12'(k));
      wr(OFF_TIMING_GEN_CTRL, 8'h04);
      wr(OFF_TIMING_GEN_CTRL, 8'h00);
    end
    $display("test timing_ram done");
    wr(OFF_ADC_INTERFACE_CTRL, 8'h9d);
    wr(OFF_WHITE_CRUSH_DOWN, 8'h00);
    wr(OFF_ODD_FIELD_TIMING, 8'h87);
    wr(OFF_SOFT_RESET_COMMAND, 8'h00);
    cyc(2);
    rchk(OFF_ADC_INTERFACE_CTRL, 8'h82);
    rchk(OFF_WHITE_CRUSH_DOWN, 8'h7f);
    rchk(OFF_ODD_FIELD_TIMING, 8'h00);
    chk({o_chroma_sleep, o_timing_ram_addr}, 12'h100);
    $display("test soft_reset done");
    summarize();
  end
endmodule

bind video_decoder_ctrl_regs video_decoder_ctrl_regs_monitor #(.RAM_AW(RAM_AW))
  i_video_decoder_ctrl_regs_monitor (.i_clock, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
  .i_reg_wdata, .i_line_start, .o_reg_rvalid, .o_converter_ref_drive, .o_decoder_clk_enable,
  .o_chroma_sleep, .o_horizontal_reset_pulse_n, .o_crush_down_total, .o_timing_gen_run_mode,
  .o_timing_ram_addr);
